// ===== hw/rpbc_pkg.sv
// Function
// - Bit 12 selects dual or single port
// - Bit 14 clear keeps bias output tristated
// - Invert bit acts only dual, enabled
// - Dual port: bias follows transmit, invertible
// - Single port: bias high transmit, low receive
// - Single port: receive switch and amplifier swap
// - Dual port: inputs only, separate transmit amplifier
// - Hibernate freezes reference clock output level
// - Ready interrupt once idle after reset
// - Idle, doze, hibernate: enabled bias low
`default_nettype none
package rpbc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  // Address width of the register port
  localparam int ADDR_W = 6;
  // Register data width
  localparam int DATA_W = 16;
  // Control register index
  localparam logic [5:0] RF_AND_PIN_CONTROL_OFS = 6'h07;
  // Port mode select field
  localparam int PORT_MODE_SELECT_BIT = 12;
  // Bias invert field
  localparam int BIAS_OUT_INVERT_BIT = 13;
  // Bias enable field
  localparam int BIAS_OUT_ENABLE_BIT = 14;
  // Control register value after reset
  localparam logic [15:0] RF_AND_PIN_CONTROL_RST = 16'h0000;
  // Answer to an unmapped read
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  // ****************************************
  // Timing
  // ****************************************
  // Core clock rate in Hz
  localparam int CORE_CLK_HZ = 10000000;
  // Reference clock output rate in Hz
  localparam int REF_CLOCK_OUT_HZ = 1000000;
  // Core cycles per half period of the reference output
  localparam int REF_HALF_CYCLES = CORE_CLK_HZ / (2 * REF_CLOCK_OUT_HZ);
  // Width of the divider counter
  localparam int REF_CNT_W = 4;
  // ****************************************
  // Radio states
  // ****************************************
  // Radio activity as reported by the sequencer
  typedef enum logic [2:0] {
    RADIO_OFF = 3'h0,
    RADIO_IDLE = 3'h1,
    RADIO_DOZE = 3'h2,
    RADIO_HIBERNATE = 3'h3,
    RADIO_RX = 3'h4,
    RADIO_TX = 3'h5
  } rpbc_radio_t;
endpackage : rpbc_pkg
`default_nettype wire

// ===== hw/rpbc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link between control core and reference clock generator
interface rpbc_clk_if;
  // Freeze request while hibernating
  logic holdLevel;
  // Present reference clock level
  logic clkLevel;
  // Control side
  modport ctrl (output holdLevel, input clkLevel);
  // Generator side
  modport gen (input holdLevel, output clkLevel);
endinterface : rpbc_clk_if
`default_nettype wire

// ===== hw/rpbc_ref_clock.sv
`timescale 1ns/1ps
`default_nettype none
// Reference clock output divider with hold
module rpbc_ref_clock (
  input wire logic core_clk,
  input wire logic rst_n,
  rpbc_clk_if.gen link
);
  // ****************************************
  // Divider state
  // ****************************************
  // Half period counter
  logic [rpbc_pkg::REF_CNT_W-1:0] cnt_reg, cnt_next;
  // Output level
  logic level_reg, level_next;

  // Next value of counter and level
  always_comb begin
    cnt_next = cnt_reg;
    level_next = level_reg;
    if (link.holdLevel) begin
      // Frozen: keep level, restart count
      cnt_next = '0;
    end else if (cnt_reg ==
        rpbc_pkg::REF_CNT_W'(rpbc_pkg::REF_HALF_CYCLES - 1)) begin
      // Half period done: toggle
      cnt_next = '0;
      level_next = ~level_reg;
    end else begin
      // Count on
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // Register divider state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      level_reg <= level_next;
    end
  end

  // Level to the control side
  assign link.clkLevel = level_reg;
endmodule : rpbc_ref_clock
`default_nettype wire

// ===== hw/rpbc_top.sv
`timescale 1ns/1ps
`default_nettype none
// RF port, bias switch and ready interrupt control
module rpbc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  // Register write strobe
  input wire logic regWrEn,
  // Register address
  input wire logic [5:0] regAddr,
  // Register write data
  input wire logic [15:0] regWrData,
  // Register read data
  output logic [15:0] regRdData,
  // Radio state from the sequencer
  input wire logic [2:0] radioState,
  // Host acknowledge of the ready interrupt
  input wire logic irqClear,
  // Bias switch pin value
  output logic biasSwitchOut,
  // Bias switch enable, low drives
  output logic biasSwitchOe_n,
  // Internal receive switch closed to LNA
  output logic rxSwitchClose,
  // Amplifier on the shared pin pair
  output logic sharedAmpEnable,
  // Amplifier on the separate output pair
  output logic dedicatedAmpEnable,
  // Reference clock output
  output logic refClockOut,
  // Open drain interrupt, value and enable
  output logic irqOut,
  output logic irqOe_n
);
  // ****************************************
  // Control register
  // ****************************************
  // Stored control word
  logic [15:0] ctrl_reg, ctrl_next;
  // Field view: one selects the shared pin pair
  logic singlePort;
  // Field view: bias pin driven at all
  logic biasEnable;
  // Field view: dual port bias polarity
  logic biasInvert;

  // Address decode used by read and write
  function automatic logic hitCtrl(input logic [5:0] addr);
    hitCtrl = (addr == rpbc_pkg::RF_AND_PIN_CONTROL_OFS);
  endfunction : hitCtrl

  // Next control word on write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (regWrEn && hitCtrl(regAddr)) begin
      ctrl_next = regWrData;
    end
  end

  // Register control word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= rpbc_pkg::RF_AND_PIN_CONTROL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign singlePort = ctrl_reg[rpbc_pkg::PORT_MODE_SELECT_BIT];
  // Bias enable and polarity fields
  assign biasEnable = ctrl_reg[rpbc_pkg::BIAS_OUT_ENABLE_BIT];
  assign biasInvert = ctrl_reg[rpbc_pkg::BIAS_OUT_INVERT_BIT];

  // Read mux, unmapped reads zero
  always_comb begin
    if (hitCtrl(regAddr)) begin
      // Mapped control word
      regRdData = ctrl_reg;
    end else begin
      // Unmapped index
      regRdData = rpbc_pkg::UNMAPPED_READ;
    end
  end

  // ****************************************
  // RF path outputs
  // ****************************************
  // Registered pin state
  // Bias pin level
  logic bias_reg, bias_next;
  // Bias pin output enable, low drives
  logic biasOeN_reg, biasOeN_next;
  // Receive switch to the low-noise amplifier
  logic rxSw_reg, rxSw_next;
  // Amplifier on the shared pair
  logic shAmp_reg, shAmp_next;
  // Amplifier on the separate pair
  logic dedAmp_reg, dedAmp_next;
  // Decoded activity
  logic isTx, isRx, isQuiet;

  // Transmit, receive and low-power decode
  assign isTx = (radioState == rpbc_pkg::RADIO_TX);
  assign isRx = (radioState == rpbc_pkg::RADIO_RX);
  assign isQuiet = (radioState == rpbc_pkg::RADIO_IDLE) ||
                   (radioState == rpbc_pkg::RADIO_DOZE) ||
                   (radioState == rpbc_pkg::RADIO_HIBERNATE);

  // Next values of all RF path outputs
  always_comb begin
    bias_next = 1'b0;
    biasOeN_next = 1'b1;
    rxSw_next = 1'b0;
    shAmp_next = 1'b0;
    dedAmp_next = 1'b0;
    if (singlePort) begin
      rxSw_next = isRx;
      shAmp_next = isTx;
    end else begin
      rxSw_next = isRx;
      dedAmp_next = isTx;
    end
    if (biasEnable) begin
      if (isQuiet) begin
        biasOeN_next = 1'b0;
        bias_next = 1'b0;
      end else if (isTx || isRx) begin
        biasOeN_next = 1'b0;
        if (singlePort) begin
          bias_next = isTx;
        end else begin
          bias_next = isTx ^ biasInvert;
        end
      end else begin
        // Off state: leave the pin floating
        biasOeN_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_reg <= 1'b0;
      biasOeN_reg <= 1'b1;
      rxSw_reg <= 1'b0;
      shAmp_reg <= 1'b0;
      dedAmp_reg <= 1'b0;
    end else begin
      bias_reg <= bias_next;
      biasOeN_reg <= biasOeN_next;
      rxSw_reg <= rxSw_next;
      shAmp_reg <= shAmp_next;
      dedAmp_reg <= dedAmp_next;
    end
  end

  // Flip-flops straight to the pins, no glitch path
  assign biasSwitchOut = bias_reg;
  assign biasSwitchOe_n = biasOeN_reg;
  assign rxSwitchClose = rxSw_reg;
  assign sharedAmpEnable = shAmp_reg;
  assign dedicatedAmpEnable = dedAmp_reg;

  // ****************************************
  // Ready interrupt
  // ****************************************
  // Ready already signalled since reset
  logic done_reg, done_next;
  // Pending request
  logic irq_reg, irq_next;

  // Next interrupt state, set beats clear
  always_comb begin
    done_next = done_reg;
    irq_next = irq_reg;
    if (irqClear) begin
      irq_next = 1'b0;
    end
    if (!done_reg && (radioState == rpbc_pkg::RADIO_IDLE)) begin
      done_next = 1'b1;
      irq_next = 1'b1;
    end
  end

  // Register interrupt state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      irq_reg <= irq_next;
    end
  end

  // Open drain: pull low while pending
  // Value fixed low, only the enable moves: no drive fight
  assign irqOut = 1'b0;
  assign irqOe_n = ~irq_reg;

  // ****************************************
  // Reference clock output
  // ****************************************
  // Link to the divider
  rpbc_clk_if clkLink ();
  // Hold the level while hibernating
  assign clkLink.holdLevel = (radioState == rpbc_pkg::RADIO_HIBERNATE);

  // Divider instance
  rpbc_ref_clock u_rpbc_ref_clock (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link(clkLink.gen)
  );

  assign refClockOut = clkLink.clkLevel;
endmodule : rpbc_top
`default_nettype wire

// ===== tb/rpbc_top_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port checker for the bias and amplifier control
module rpbc_top_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [2:0] radioState,
  input wire logic irqClear,
  input wire logic biasSwitchOut,
  input wire logic biasSwitchOe_n,
  input wire logic rxSwitchClose,
  input wire logic sharedAmpEnable,
  input wire logic dedicatedAmpEnable,
  input wire logic refClockOut,
  input wire logic irqOe_n
);
  logic [15:0] ctrlShadow_reg; // Shadow of the control word
  logic seenIdle_reg; // Idle reached since reset
  logic en, inv, sgl, tx, rx, low; // Field and state decode
  logic dualLvl, shAmp, ddAmp; // Expected levels one cycle on
  assign en = ctrlShadow_reg[14];
  assign inv = ctrlShadow_reg[13];
  assign sgl = ctrlShadow_reg[12];
  assign tx = radioState == 3'h5;
  assign rx = radioState == 3'h4;
  assign low = radioState inside {3'h1, 3'h2, 3'h3};
  assign dualLvl = tx ^ inv;
  assign shAmp = tx && sgl;
  assign ddAmp = tx && !sgl;
  // Track writes and the first idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlShadow_reg <= 16'h0000;
      seenIdle_reg <= 1'b0;
    end else begin
      if (regWrEn && regAddr == 6'h07) begin
        ctrlShadow_reg <= regWrData;
      end
      seenIdle_reg <= seenIdle_reg | (radioState == 3'h1);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_OE_OFF: assert property (!en |=> biasSwitchOe_n)
    else $error("bias driven while disabled");
  AST_OE_ON: assert property (
    en && (low || tx || rx) |=> !biasSwitchOe_n)
    else $error("bias not driven while enabled");
  AST_SGL: assert property (
    en && sgl && (tx || rx) |=> biasSwitchOut == $past(tx))
    else $error("single port bias level");
  AST_DUAL: assert property (
    en && !sgl && (tx || rx) |=> biasSwitchOut == $past(dualLvl))
    else $error("dual port bias level");
  AST_LOW: assert property (en && low |=> !biasSwitchOut)
    else $error("bias not low in quiet state");
  AST_RXSW: assert property (1'b1 |=> rxSwitchClose == $past(rx))
    else $error("receive switch wrong");
  AST_SHAMP: assert property (
    1'b1 |=> sharedAmpEnable == $past(shAmp))
    else $error("shared amplifier wrong");
  AST_DDAMP: assert property (
    1'b1 |=> dedicatedAmpEnable == $past(ddAmp))
    else $error("dedicated amplifier wrong");
  AST_HOLD: assert property (
    (radioState == 3'h3) [*2] |=> $stable(refClockOut))
    else $error("reference clock moved in hibernate");
  AST_READY: assert property (
    radioState == 3'h1 && !seenIdle_reg |=> !irqOe_n)
    else $error("ready request missing");
endmodule : rpbc_top_props
bind rpbc_top rpbc_top_props u_rpbc_top_props (.core_clk, .rst_n, .regWrEn,
  .regAddr, .regWrData, .radioState, .irqClear, .biasSwitchOut,
  .biasSwitchOe_n, .rxSwitchClose, .sharedAmpEnable, .dedicatedAmpEnable,
  .refClockOut, .irqOe_n);
`default_nettype wire

// ===== tb/rpbc_ext_balun.sv
`timescale 1ns/1ps
`default_nettype none
// Balun centre tap seen from outside; floats when released
module rpbc_ext_balun (
  input wire logic core_clk,
  input wire logic biasSwitchOut,
  input wire logic biasSwitchOe_n,
  output logic biasLine
);
  logic lastLevel = 1'b0; // Last driven or wandering level
  // Released line wanders every cycle
  always @(posedge core_clk) begin
    lastLevel <= biasSwitchOe_n ? ~lastLevel : biasSwitchOut;
  end
  assign biasLine = biasSwitchOe_n ? ~lastLevel : biasSwitchOut;
endmodule : rpbc_ext_balun
`default_nettype wire

// ===== tb/test_rf_port_bias_switch_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_rf_port_bias_switch_control;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn = 1'b0;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000;
  logic [2:0] radioState = 3'h0;
  logic irqClear = 1'b0;
  logic [15:0] regRdData;
  logic biasSwitchOut, biasSwitchOe_n, rxSwitchClose, sharedAmpEnable;
  logic dedicatedAmpEnable, refClockOut, irqOut, irqOe_n, biasLine, irqLine;
  int numErrors = 0;
  int nCompared = 0;
  always #50 core_clk = ~core_clk;
  // Open drain request with host pull-up
  assign irqLine = irqOe_n ? 1'b1 : irqOut;
  rpbc_top u_rpbc_top (.core_clk, .rst_n, .regWrEn, .regAddr, .regWrData,
    .regRdData, .radioState, .irqClear, .biasSwitchOut, .biasSwitchOe_n,
    .rxSwitchClose, .sharedAmpEnable, .dedicatedAmpEnable, .refClockOut,
    .irqOut, .irqOe_n);
  rpbc_ext_balun u_rpbc_ext_balun (.core_clk, .biasSwitchOut,
    .biasSwitchOe_n, .biasLine);
  task finishTest;
    $display("errors %0d compared %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finishTest
  task chkw(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask : chkw
  task chk1(input logic got, input logic exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: bit %b want %b", $time, got, exp);
    end
  endtask : chk1
  task wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask : wr
  task go(input logic [2:0] s, input int n);
    @(negedge core_clk);
    radioState = s;
    repeat (n) @(negedge core_clk);
  endtask : go
  // Reset values, ready request once, then cleared
  task t_ready;
    chk1(biasSwitchOe_n, 1'b1);
    regAddr = 6'h07;
    #1 chkw(regRdData, 16'h0000);
    chk1(irqLine, 1'b1);
    go(3'h1, 3);
    chk1(irqLine, 1'b0);
    irqClear = 1'b1;
    @(negedge core_clk);
    irqClear = 1'b0;
    repeat (4) @(negedge core_clk);
    chk1(irqLine, 1'b1);
  endtask : t_ready
  // Full word stored, unmapped index ignored
  task t_reg;
    wr(6'h07, 16'hFFFF);
    wr(6'h08, 16'h1234);
    #1 chkw(regRdData, 16'h0000);
    @(negedge core_clk);
    regAddr = 6'h07;
    #1 chkw(regRdData, 16'hFFFF);
  endtask : t_reg
  // Every mode bit combination in every radio state
  task t_table;
    logic en, inv, sgl, tx;
    for (int c = 0; c < 8; c++) begin
      wr(6'h07, {1'b0, c[2:0], 12'h000});
      {en, inv, sgl} = c[2:0];
      for (int s = 0; s < 6; s++) begin
        go(s[2:0], 2);
        tx = s == 5;
        chk1(biasSwitchOe_n, !(en && s != 0));
        if (en && s != 0) begin
          chk1(biasLine, s < 4 ? 1'b0 : (sgl ? tx : tx ^ inv));
        end
        chk1(rxSwitchClose, s == 4);
        chk1(sharedAmpEnable, tx && sgl);
        chk1(dedicatedAmpEnable, tx && !sgl);
      end
    end
  endtask : t_table
  // Reference clock frozen in hibernate, runs again in idle
  task t_hib;
    logic lv, moved;
    int n;
    go(3'h3, 2);
    lv = refClockOut;
    moved = 1'b0;
    repeat (12) begin
      @(negedge core_clk);
      chk1(refClockOut, lv);
    end
    go(3'h1, 0);
    repeat (12) begin
      @(negedge core_clk);
      moved = moved | (refClockOut !== lv);
    end
    chk1(moved, 1'b1);
    // Running output: first wait aligns, second measures half period
    repeat (2) begin
      lv = refClockOut;
      n = 0;
      while (refClockOut === lv && n < 20) begin
        @(negedge core_clk);
        n++;
      end
    end
    chkw(16'(n), 16'(rpbc_pkg::REF_HALF_CYCLES));
  endtask : t_hib
  // Mid-run reset: cleared state, one fresh ready request
  task t_rst;
    @(negedge core_clk);
    rst_n = 1'b0;
    radioState = 3'h0;
    regAddr = 6'h07;
    repeat (2) @(negedge core_clk);
    chk1(biasSwitchOe_n, 1'b1);
    chkw(regRdData, 16'h0000);
    chk1(irqLine, 1'b1);
    rst_n = 1'b1;
    @(negedge core_clk);
    // Clear meets the first idle edge: the request must win
    radioState = 3'h1;
    irqClear = 1'b1;
    @(negedge core_clk);
    irqClear = 1'b0;
    @(negedge core_clk);
    chk1(irqLine, 1'b0);
    irqClear = 1'b1;
    @(negedge core_clk);
    irqClear = 1'b0;
    go(3'h0, 1);
    go(3'h1, 2);
    chk1(irqLine, 1'b1);
  endtask : t_rst
  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    t_ready;
    t_reg;
    t_table;
    t_hib;
    t_rst;
    finishTest;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    finishTest;
  end
endmodule : test_rf_port_bias_switch_control
`default_nettype wire
